// ===== ocm_clkdiv.sv
`timescale 1ns/1ps
module ocm_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       bypass,
  input  wire logic [2:0] exp_sel,
  output logic            en
);
  logic [5:0] cnt_ff;
  logic [5:0] mask;

  // Ratio is a power of two, so a mask compare replaces a reload counter
  assign mask = 6'((7'h01 << exp_sel) - 7'h01);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 6'h00;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en <= 1'b0;
    end else begin
      en <= tick && (bypass || ((cnt_ff & mask) == mask));
    end
  end
endmodule

// ===== ocm_defines.svh
`ifndef OCM_DEFINES_SVH
`define OCM_DEFINES_SVH

// Register address width and byte addresses
`define OCM_AW           8
`define OCM_OFS_SMC      8'h00
`define OCM_OFS_CTRL     8'h04
`define OCM_OFS_STAT     8'h08

// system_mode_control fields
`define OCM_DIV_HI       7
`define OCM_DIV_LO       5
`define OCM_FWAKE_BIT    4
`define OCM_LRDY_BIT     3
`define OCM_HRDY_BIT     2
`define OCM_IDLE_BIT     1
`define OCM_HSEL_BIT     0
`define OCM_SMC_RESET    8'h03
`define OCM_SMC_WMASK    8'hF3

// ctrl fields
`define OCM_SYSIDLE_BIT  7
`define OCM_CTRL_RESET   8'h00

// Divider encoding: exponent of ratio is OCM_DIV_EXP_TOP minus the code
`define OCM_DIV_EXP_BASE 3'h0
`define OCM_DIV_EXP_TOP  4'h8

// Oscillator settle counts, in oscillator cycles
`define OCM_HXT_SETTLE   10'h200
`define OCM_HS_RC_OSC_SETTLE  10'h010
`define OCM_LXT_SETTLE   10'h080
`define OCM_LS_RC_OSC_SETTLE  10'h002

// AXI responses
`define OCM_RESP_OKAY    2'h0
`define OCM_RESP_SLVERR  2'h2

`endif

// ===== ocm_pkg.sv
package ocm_pkg;
  typedef enum logic [5:0] {
    OCM_FAST_RUN    = 6'h01,
    OCM_SLOW_RUN    = 6'h02,
    OCM_FULL_SLEEP  = 6'h04,
    OCM_SLEEP_SUB   = 6'h08,
    OCM_IDLE_OFF    = 6'h10,
    OCM_IDLE_ON     = 6'h20
  } ocm_mode_t;
endpackage

// ===== ocm_sync.sv
`timescale 1ns/1ps
module ocm_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ===== ocm_tb.sv
`timescale 1ns/1ps
`include "ocm_defines.svh"
module testbench;
  logic        clk, rst_b, halt, wdt_en, lv_en, hs_xtal, ls_xtal, wake, hs_tick, ls_tick;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, tdiv;
  logic        cpu_en, sys_en, hs_en, sub_en, wdt_run, refused;
  logic [5:0]  mode;
  int          mismatches, check_count;

  ocm_top u_ocm_top (
    .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .HALT_REQ(halt), .WDT_EN(wdt_en), .LV_DETECT_EN(lv_en), .HS_IS_CRYSTAL(hs_xtal),
    .LS_IS_CRYSTAL(ls_xtal), .WAKE(wake), .HS_TICK(hs_tick), .LS_TICK(ls_tick),
    .CPU_CLK_EN(cpu_en), .SYS_CLK_EN(sys_en), .HS_OSC_EN(hs_en), .SUB_OSC_EN(sub_en),
    .WDT_RUN(wdt_run), .HALT_REFUSED(refused), .MODE(mode));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Oscillators: two cycles high, two low, so each tick edge is seen
  always @(posedge clk) begin
    tdiv    <= tdiv + 2'h1;
    hs_tick <= tdiv[1];
    ls_tick <= tdiv[1];
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Tick phase against the divider is unknown, so one pulse either way is allowed
  task automatic chk_cnt(input string nm, input int exp, input int got);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic timeout(input string nm);
    mismatches++;
    $display("BAD %s expected answer seen none", nm);
    final_report();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_t, w_t;
    int   n;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    while (awvalid || wvalid) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
      if (n > 50) timeout("write handshake");
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 50) timeout("write response");
    end while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 50) timeout("read address");
    end while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 50) timeout("read data");
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_val("bresp", `OCM_RESP_OKAY, r);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_val(nm, exp, d & m);
    chk_val("rresp", `OCM_RESP_OKAY, r);
  endtask

  task automatic do_halt(input logic w, input logic lv, output logic rf);
    @(posedge clk);
    wdt_en <= w;
    lv_en  <= lv;
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    rf = 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (refused === 1'b1) rf = 1'b1;
    end
  endtask

  task automatic do_wake;
    int n;
    @(posedge clk);
    wake <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 50) timeout("wake");
    end while (cpu_en !== 1'b1);
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk_val("mode after wake", {2'h0, ocm_pkg::OCM_FAST_RUN}, {2'h0, mode});
  endtask

  task automatic sc_reset_regs;
    logic [7:0] d;
    logic [1:0] r;
    rd_chk("smc reset", `OCM_OFS_SMC, 8'hFF, 8'h03);
    rd_chk("ctrl reset", `OCM_OFS_CTRL, 8'hFF, 8'h00);
    chk_val("mode reset", {2'h0, ocm_pkg::OCM_FAST_RUN}, {2'h0, mode});
    axi_rd(8'h0C, d, r);
    chk_val("unmapped rresp", `OCM_RESP_SLVERR, r);
    axi_wr(`OCM_OFS_STAT, 8'hFF, r);
    chk_val("status bresp", `OCM_RESP_SLVERR, r);
  endtask

  task automatic sc_ready_flags;
    repeat (300) @(posedge clk);
    rd_chk("high ready only", `OCM_OFS_SMC, 8'hFF, 8'h07);
    repeat (400) @(posedge clk);
    rd_chk("both ready", `OCM_OFS_SMC, 8'hFF, 8'h0F);
  endtask

  task automatic sc_reg_access;
    wr(`OCM_OFS_SMC, 8'hE3);
    rd_chk("smc flags kept", `OCM_OFS_SMC, 8'hFF, 8'hEF);
    wr(`OCM_OFS_SMC, 8'h13);
    rd_chk("smc fast wake", `OCM_OFS_SMC, 8'hFF, 8'h1F);
    wr(`OCM_OFS_SMC, 8'h03);
    wr(`OCM_OFS_CTRL, 8'h80);
    rd_chk("ctrl idle clock", `OCM_OFS_CTRL, 8'h80, 8'h80);
    wr(`OCM_OFS_CTRL, 8'h00);
  endtask

  task automatic count_sys(output int cnt);
    cnt = 0;
    repeat (512) begin
      @(negedge clk);
      if (sys_en === 1'b1) cnt++;
    end
  endtask

  task automatic sc_divider;
    int cnt;
    for (int c = 7; c >= 0; c--) begin
      wr(`OCM_OFS_SMC, {c[2:0], 5'h00});
      repeat (100) @(posedge clk);
      count_sys(cnt);
      if (c >= 2) begin
        chk_val("mode divided", {2'h0, ocm_pkg::OCM_FAST_RUN}, {2'h0, mode});
        chk_cnt("divided clock", 128 >> (8 - c), cnt);
      end else begin
        chk_val("mode sub", {2'h0, ocm_pkg::OCM_SLOW_RUN}, {2'h0, mode});
        chk_val("high osc slow", 8'h00, {7'h00, hs_en});
        chk_cnt("sub clock", 128, cnt);
      end
    end
    wr(`OCM_OFS_SMC, 8'h01);
    repeat (100) @(posedge clk);
    count_sys(cnt);
    chk_cnt("undivided clock", 128, cnt);
    wr(`OCM_OFS_SMC, 8'h03);
  endtask

  task automatic sc_idle;
    logic rf;
    wr(`OCM_OFS_CTRL, 8'h80);
    do_halt(1'b1, 1'b0, rf);
    chk_val("mode idle on", {2'h0, ocm_pkg::OCM_IDLE_ON}, {2'h0, mode});
    chk_val("cpu idle on", 8'h00, {7'h00, cpu_en});
    chk_val("high osc idle on", 8'h01, {7'h00, hs_en});
    repeat (20) @(posedge clk);
    chk_val("mode held", {2'h0, ocm_pkg::OCM_IDLE_ON}, {2'h0, mode});
    do_wake();
    wr(`OCM_OFS_CTRL, 8'h00);
    do_halt(1'b1, 1'b0, rf);
    chk_val("mode idle off", {2'h0, ocm_pkg::OCM_IDLE_OFF}, {2'h0, mode});
    chk_val("osc idle off", 8'h00, {6'h00, cpu_en, hs_en});
    chk_val("wdt idle off", 8'h01, {7'h00, wdt_run});
    rd_chk("high ready idle off", `OCM_OFS_SMC, 8'h04, 8'h00);
    do_wake();
  endtask

  task automatic sc_sleep;
    logic rf;
    wr(`OCM_OFS_SMC, 8'h01);
    do_halt(1'b1, 1'b0, rf);
    chk_val("mode sleep sub", {2'h0, ocm_pkg::OCM_SLEEP_SUB}, {2'h0, mode});
    chk_val("sub on sleep", 8'h01, {6'h00, cpu_en, sub_en});
    do_wake();
    do_halt(1'b0, 1'b1, rf);
    chk_val("refused pulse", 8'h01, {7'h00, rf});
    chk_val("mode refused", {2'h0, ocm_pkg::OCM_FAST_RUN}, {2'h0, mode});
    do_halt(1'b0, 1'b0, rf);
    chk_val("mode full sleep", {2'h0, ocm_pkg::OCM_FULL_SLEEP}, {2'h0, mode});
    chk_val("all off sleep", 8'h00, {5'h00, cpu_en, sub_en, wdt_run});
    rd_chk("ready low sleep", `OCM_OFS_SMC, 8'h0C, 8'h00);
    do_wake();
    repeat (600) @(posedge clk);
    rd_chk("ready after wake", `OCM_OFS_SMC, 8'h0C, 8'h0C);
    wr(`OCM_OFS_SMC, 8'h03);
  endtask

  // Divide by 64 is chosen so the sub clock stand-in is told apart by rate
  task automatic sc_fast_wake;
    int   cnt;
    logic rf;
    hs_xtal <= 1'b1;
    wr(`OCM_OFS_SMC, 8'h50);
    do_halt(1'b1, 1'b0, rf);
    chk_val("mode fast wake sleep", {2'h0, ocm_pkg::OCM_SLEEP_SUB}, {2'h0, mode});
    do_wake();
    rd_chk("fast wake on", `OCM_OFS_STAT, 8'h80, 8'h80);
    count_sys(cnt);
    chk_cnt("sub clock on wake", 128, cnt);
    repeat (1700) @(posedge clk);
    rd_chk("crystal ready", `OCM_OFS_SMC, 8'h04, 8'h04);
    rd_chk("fast wake off", `OCM_OFS_STAT, 8'h80, 8'h00);
    count_sys(cnt);
    chk_cnt("divided after wake", 2, cnt);
    wr(`OCM_OFS_SMC, 8'h03);
  endtask

  initial begin
    rst_b = 1'b0;
    {awaddr, araddr, wdata, wstrb, tdiv} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {halt, wdt_en, lv_en, hs_xtal, wake, hs_tick, ls_tick} = '0;
    ls_xtal = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    sc_reset_regs();
    sc_ready_flags();
    sc_reg_access();
    sc_divider();
    sc_idle();
    sc_sleep();
    sc_fast_wake();
    final_report();
  end
endmodule

// ===== ocm_top.sv
// Operation
// - Fast run clocks the system from the high clock divided by 1 to 64 per divider and select.
// - Slow run clocks the CPU from the low speed oscillator and keeps the high clock off.
// - Halting into full sleep stops the CPU, the sub clock and the watchdog.
// - Full sleep is refused while low-voltage detect is enabled; software clears it first.
// - A sleep halt with the watchdog enabled enters sleep with the sub clock kept running.
// - An idle halt with system clock in idle off stops the system oscillator and CPU only.
// - An idle halt with system clock in idle on gates the CPU but keeps the oscillator running.
// - The mode register holds divider 7:5, fast wake 4, two ready flags 3:2, idle 1, select 0.
// - With select low, divider codes 000/001 pick the sub clock and 010..111 pick /64../2.
// - Fast wake with the crystal, waking from sleep-sub or idle-off, runs the system on the sub clock until the high clock settles.
// - Low ready is low in full sleep and after reset, then rises after 128 or 2 cycles.
// - Select high picks the undivided high clock; moving to the sub clock stops the high osc.
// - High ready clears in sleep and idle-off and rises after 512 or 16 oscillator cycles.
// - A separate bit, reset to zero, keeps the system clock running in idle.
`timescale 1ns/1ps
`include "ocm_defines.svh"
module ocm_top (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // AXI4-Lite write
  input  wire logic [`OCM_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [`OCM_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // CPU and system side
  input  wire logic              HALT_REQ,
  input  wire logic              WDT_EN,
  input  wire logic              LV_DETECT_EN,
  input  wire logic              HS_IS_CRYSTAL,
  input  wire logic              LS_IS_CRYSTAL,
  // Oscillator and wake pins
  input  wire logic              WAKE,
  input  wire logic              HS_TICK,
  input  wire logic              LS_TICK,
  // Clock controls and status
  output logic                   CPU_CLK_EN,
  output logic                   SYS_CLK_EN,
  output logic                   HS_OSC_EN,
  output logic                   SUB_OSC_EN,
  output logic                   WDT_RUN,
  output logic                   HALT_REFUSED,
  output logic [5:0]             MODE
);
  ocm_pkg::ocm_mode_t mode_ff;
  ocm_pkg::ocm_mode_t nxt_mode;
  logic [7:0]  smc_ff;
  logic        sysidle_ff;
  logic        hrdy_ff;
  logic        lrdy_ff;
  logic [9:0]  hcnt_ff;
  logic [9:0]  lcnt_ff;
  logic        fw_ff;
  logic [2:0]  pin_s;
  logic [2:0]  pin_d_ff;
  logic        wake_p;
  logic        hs_p;
  logic        ls_p;
  logic        div_en;
  logic        run;
  logic        lowp;
  logic        want_sub;
  logic        refuse;
  logic        hs_on;
  logic        nxt_sys;

  // codes 000 and 001 steer the system onto the sub clock
  function automatic logic sel_sub(input logic [7:0] r);
    return !r[`OCM_HSEL_BIT] && (r[`OCM_DIV_HI:`OCM_DIV_LO-1+2] == 2'h0);
  endfunction

  function automatic logic is_lp(input ocm_pkg::ocm_mode_t m);
    return m inside {ocm_pkg::OCM_FULL_SLEEP, ocm_pkg::OCM_SLEEP_SUB,
                     ocm_pkg::OCM_IDLE_OFF, ocm_pkg::OCM_IDLE_ON};
  endfunction

  ocm_sync #(
    .W (3)
  ) u_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     ({WAKE, HS_TICK, LS_TICK}),
    .q     (pin_s)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_d_ff <= 3'h0;
    end else begin
      pin_d_ff <= pin_s;
    end
  end

  assign wake_p   = pin_s[2] && !pin_d_ff[2];
  assign hs_p     = pin_s[1] && !pin_d_ff[1];
  assign ls_p     = pin_s[0] && !pin_d_ff[0];
  assign run      = mode_ff inside {ocm_pkg::OCM_FAST_RUN, ocm_pkg::OCM_SLOW_RUN};
  assign lowp     = is_lp(mode_ff);
  assign want_sub = sel_sub(smc_ff);
  // no watchdog means full sleep, which low-voltage detect blocks
  assign refuse   = run && HALT_REQ && !smc_ff[`OCM_IDLE_BIT] && !WDT_EN && LV_DETECT_EN;

  // high clock divided; select high bypasses the divider
  ocm_clkdiv u_div (
    .clk     (CLK),
    .rst_b   (RST_B),
    .tick    (hs_p),
    .bypass  (smc_ff[`OCM_HSEL_BIT]),
    .exp_sel (3'(`OCM_DIV_EXP_TOP - {1'b0, smc_ff[`OCM_DIV_HI:`OCM_DIV_LO]})),
    .en      (div_en)
  );

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      ocm_pkg::OCM_FAST_RUN, ocm_pkg::OCM_SLOW_RUN: begin
        // bits sampled in the halt cycle
        if (HALT_REQ && !refuse) begin
          if (smc_ff[`OCM_IDLE_BIT]) begin
            nxt_mode = sysidle_ff ? ocm_pkg::OCM_IDLE_ON
                                  : ocm_pkg::OCM_IDLE_OFF;
          end else begin
            nxt_mode = WDT_EN ? ocm_pkg::OCM_SLEEP_SUB
                              : ocm_pkg::OCM_FULL_SLEEP;
          end
        end else if (!HALT_REQ) begin
          nxt_mode = want_sub ? ocm_pkg::OCM_SLOW_RUN : ocm_pkg::OCM_FAST_RUN;
        end
      end
      ocm_pkg::OCM_FULL_SLEEP, ocm_pkg::OCM_SLEEP_SUB,
      ocm_pkg::OCM_IDLE_OFF, ocm_pkg::OCM_IDLE_ON: begin
        if (wake_p) begin
          nxt_mode = want_sub ? ocm_pkg::OCM_SLOW_RUN : ocm_pkg::OCM_FAST_RUN;
        end
      end
      default: nxt_mode = ocm_pkg::OCM_FAST_RUN;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_ff <= ocm_pkg::OCM_FAST_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // only a crystal high osc waking from a mode with live sub clock
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fw_ff <= 1'b0;
    end else if (wake_p && (mode_ff inside {ocm_pkg::OCM_SLEEP_SUB, ocm_pkg::OCM_IDLE_OFF})
                 && !want_sub && smc_ff[`OCM_FWAKE_BIT] && HS_IS_CRYSTAL) begin
      fw_ff <= 1'b1;
    end else if (hrdy_ff || mode_ff != ocm_pkg::OCM_FAST_RUN) begin
      fw_ff <= 1'b0;
    end
  end

  // high osc only runs while something uses it
  assign hs_on = (mode_ff == ocm_pkg::OCM_FAST_RUN)
              || (mode_ff == ocm_pkg::OCM_IDLE_ON && !want_sub);

  // high ready restarts from zero in sleep and idle-off
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hcnt_ff <= 10'h000;
      hrdy_ff <= 1'b0;
    end else if (mode_ff inside {ocm_pkg::OCM_FULL_SLEEP, ocm_pkg::OCM_SLEEP_SUB,
                                 ocm_pkg::OCM_IDLE_OFF}) begin
      hcnt_ff <= 10'h000;
      hrdy_ff <= 1'b0;
    end else if (hs_on && hs_p && !hrdy_ff) begin
      hcnt_ff <= hcnt_ff + 10'h001;
      hrdy_ff <= (hcnt_ff + 10'h001) ==
                 (HS_IS_CRYSTAL ? `OCM_HXT_SETTLE : `OCM_HS_RC_OSC_SETTLE);
    end
  end

  // low ready drops only in full sleep
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lcnt_ff <= 10'h000;
      lrdy_ff <= 1'b0;
    end else if (mode_ff == ocm_pkg::OCM_FULL_SLEEP) begin
      lcnt_ff <= 10'h000;
      lrdy_ff <= 1'b0;
    end else if (ls_p && !lrdy_ff) begin
      lcnt_ff <= lcnt_ff + 10'h001;
      lrdy_ff <= (lcnt_ff + 10'h001) ==
                 (LS_IS_CRYSTAL ? `OCM_LXT_SETTLE : `OCM_LS_RC_OSC_SETTLE);
    end
  end

  always_comb begin
    unique case (mode_ff)
      ocm_pkg::OCM_FAST_RUN: nxt_sys = fw_ff ? ls_p : div_en;
      ocm_pkg::OCM_SLOW_RUN: nxt_sys = ls_p;
      ocm_pkg::OCM_IDLE_ON:  nxt_sys = want_sub ? ls_p : div_en;
      default:               nxt_sys = 1'b0;
    endcase
  end

  // Outputs trail mode_ff by one cycle so every one is a flop
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CPU_CLK_EN   <= 1'b0;
      SYS_CLK_EN   <= 1'b0;
      HS_OSC_EN    <= 1'b0;
      SUB_OSC_EN   <= 1'b0;
      WDT_RUN      <= 1'b0;
      HALT_REFUSED <= 1'b0;
      MODE         <= 6'h00;
    end else begin
      CPU_CLK_EN   <= run;
      SYS_CLK_EN   <= nxt_sys;
      HS_OSC_EN    <= hs_on;
      SUB_OSC_EN   <= mode_ff != ocm_pkg::OCM_FULL_SLEEP;
      WDT_RUN      <= WDT_EN && mode_ff != ocm_pkg::OCM_FULL_SLEEP;
      HALT_REFUSED <= refuse;
      MODE         <= mode_ff;
    end
  end

  // Register slave: one write and one read in flight
  logic                aw_got_ff;
  logic                w_got_ff;
  logic [`OCM_AW-1:0] awaddr_ff;
  logic [7:0]          wdata_ff;
  logic                wstrb_ff;
  logic                nxt_aw_got;
  logic                nxt_w_got;
  logic                nxt_bvalid;
  logic                nxt_rvalid;
  logic                do_wr;
  logic [31:0]         rd_word;
  logic                rd_hit;

  assign do_wr      = aw_got_ff && w_got_ff && !S_AXI_BVALID;
  assign nxt_aw_got = (aw_got_ff || (S_AXI_AWVALID && S_AXI_AWREADY)) && !do_wr;
  assign nxt_w_got  = (w_got_ff || (S_AXI_WVALID && S_AXI_WREADY)) && !do_wr;
  assign nxt_bvalid = do_wr || (S_AXI_BVALID && !S_AXI_BREADY);
  assign nxt_rvalid = (S_AXI_ARVALID && S_AXI_ARREADY) || (S_AXI_RVALID && !S_AXI_RREADY);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= 8'h00;
      wstrb_ff      <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `OCM_RESP_OKAY;
    end else begin
      aw_got_ff     <= nxt_aw_got;
      w_got_ff      <= nxt_w_got;
      S_AXI_AWREADY <= !nxt_aw_got && !nxt_bvalid;
      S_AXI_WREADY  <= !nxt_w_got && !nxt_bvalid;
      S_AXI_BVALID  <= nxt_bvalid;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata_ff <= S_AXI_WDATA[7:0];
        wstrb_ff <= S_AXI_WSTRB[0];
      end
      if (do_wr) begin
        S_AXI_BRESP <= (awaddr_ff == `OCM_OFS_SMC || awaddr_ff == `OCM_OFS_CTRL)
                       ? `OCM_RESP_OKAY : `OCM_RESP_SLVERR;
      end
    end
  end

  // ready flags are live, so the stored copy keeps only writable bits
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      smc_ff     <= `OCM_SMC_RESET;
      sysidle_ff <= 1'b0;
    end else if (do_wr && wstrb_ff) begin
      if (awaddr_ff == `OCM_OFS_SMC) begin
        smc_ff <= wdata_ff & `OCM_SMC_WMASK;
      end
      if (awaddr_ff == `OCM_OFS_CTRL) begin
        sysidle_ff <= wdata_ff[`OCM_SYSIDLE_BIT];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (S_AXI_ARADDR)
      `OCM_OFS_SMC: begin
        rd_word[7:0]             = smc_ff;
        rd_word[`OCM_LRDY_BIT]   = lrdy_ff;
        rd_word[`OCM_HRDY_BIT]   = hrdy_ff;
      end
      `OCM_OFS_CTRL: rd_word[`OCM_SYSIDLE_BIT] = sysidle_ff;
      `OCM_OFS_STAT: rd_word[7:0] = {fw_ff, HALT_REFUSED, mode_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `OCM_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !nxt_rvalid;
      S_AXI_RVALID  <= nxt_rvalid;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_hit ? `OCM_RESP_OKAY : `OCM_RESP_SLVERR;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_full_sleep_off: assert property (mode_ff == ocm_pkg::OCM_FULL_SLEEP |=>
    !SUB_OSC_EN && !WDT_RUN && !CPU_CLK_EN) else $error("full sleep left clocks on");
  a_lv_refuse_hold: assert property (refuse |=>
    mode_ff == $past(mode_ff) ##0 HALT_REFUSED) else $error("full sleep not refused");
  a_sleep_sub_entry: assert property (run && HALT_REQ && !smc_ff[1] && WDT_EN |=>
    mode_ff == ocm_pkg::OCM_SLEEP_SUB ##1 SUB_OSC_EN) else $error("sleep sub not entered");
  a_idle_off_entry: assert property (run && HALT_REQ && smc_ff[1] && !sysidle_ff |=>
    mode_ff == ocm_pkg::OCM_IDLE_OFF ##1 !HS_OSC_EN) else $error("idle off wrong");
  a_idle_on_entry: assert property (run && HALT_REQ && smc_ff[1] && sysidle_ff |=>
    mode_ff == ocm_pkg::OCM_IDLE_ON ##1 !CPU_CLK_EN) else $error("idle on wrong");
  a_slow_hs_off: assert property (mode_ff == ocm_pkg::OCM_SLOW_RUN |=>
    !HS_OSC_EN && CPU_CLK_EN) else $error("high osc on in slow run");
  a_lrdy_clear: assert property (mode_ff == ocm_pkg::OCM_FULL_SLEEP |=>
    !lrdy_ff) else $error("low ready set in full sleep");
  a_hrdy_clear: assert property (mode_ff == ocm_pkg::OCM_IDLE_OFF |=>
    !hrdy_ff) else $error("high ready set in idle off");
  a_lp_hold: assert property (lowp && !wake_p |=>
    $stable(mode_ff)) else $error("low power mode left without wake");
  a_fw_sub_clock: assert property (fw_ff && mode_ff == ocm_pkg::OCM_FAST_RUN |=>
    SYS_CLK_EN == $past(ls_p)) else $error("fast wake not on sub clock");

  c_full_sleep: cover property (mode_ff == ocm_pkg::OCM_FULL_SLEEP ##[1:50] wake_p);
  c_idle_on:    cover property (mode_ff == ocm_pkg::OCM_IDLE_ON ##1 SYS_CLK_EN);
  c_fast_wake:  cover property (fw_ff ##1 !fw_ff);
  c_refused:    cover property (HALT_REFUSED);
endmodule
